// [ref_input_config_defines.svh]
// Purpose: Offsets, field positions, reset values and counts of the reference input registers.
// Assumes: Included by its bare name from the design files.
// Notes: Definitions only.
`ifndef REF_INPUT_CONFIG_DEFINES_SVH
`define REF_INPUT_CONFIG_DEFINES_SVH

`define OFS_STANDBY_PRIO 7'h1C
`define OFS_CFG_TTL1 7'h22
`define OFS_CFG_TTL2 7'h23
`define OFS_CFG_DIFF1 7'h24
`define OFS_CFG_DIFF2 7'h25
`define OFS_CFG_STANDBY 7'h28

`define RST_STANDBY_PRIO 4'h4
`define RST_CFG_TTL 8'h00
`define RST_CFG_OTHER 8'h03

`define BIT_PROG_DIV 7
`define BIT_PRESET_DIV 6
`define BIT_BUCKET_HI 5
`define BIT_BUCKET_LO 4
`define PRIO_HI 3

`define NUM_INPUTS 5
`define IDX_STANDBY 3'h4
`define PRIO_OFF 4'h0

`define SER_ADDR_LAST 5'h07
`define SER_DATA_FIRST 5'h08
`define SER_DATA_LAST 5'h0F
`define SER_FRAME_BITS 5'h10

`endif

// [ref_cfg_pkg.sv]
// Purpose: Types shared by the reference input configuration block.
// Assumes: Nothing beyond plain SystemVerilog.
// Notes: Field order of src_cfg_s matches the register bit order.
package ref_cfg_pkg;

	typedef enum logic [1:0] {PATH_DIRECT, PATH_PROG, PATH_PRESET} path_e;

	typedef struct packed {
		logic prog_div;
		logic preset_div;
		logic [1:0] bucket;
		logic [3:0] freq;
	} src_cfg_s;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed {
		path_e dpll_path;
		logic monitor_predivided;
		logic [1:0] bucket;
	} input_route_s;

endpackage

// [serial_port.sv]
// Purpose: Serial register port: one read/write flag, seven address bits, eight data bits.
// Assumes: Serial clock is slow against clock; bits are sampled on its rising edge.
// Notes: Read data leave on falling edges, most significant bit first.
`timescale 1ns/10ps
`default_nettype none
`include "ref_input_config_defines.svh"

module serial_port (
	input wire logic clock,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic [7:0] rd_data,
	output var logic [6:0] rd_addr,
	output var ref_cfg_pkg::reg_write_s wr,
	output var logic sdo,
	output var logic sdo_oe
);

	logic sclk_prev, next_sclk_prev, is_read, next_is_read;
	logic [4:0] count, next_count;
	logic [6:0] in_shift, next_in_shift, next_rd_addr;
	logic [7:0] out_shift, next_out_shift;
	logic next_sdo, next_sdo_oe;
	ref_cfg_pkg::reg_write_s next_wr;

	always_comb
	begin
		next_sclk_prev = sclk;
		next_is_read = is_read;
		next_count = count;
		next_in_shift = in_shift;
		next_rd_addr = rd_addr;
		next_out_shift = out_shift;
		next_sdo = sdo;
		next_sdo_oe = sdo_oe;
		next_wr = '0;
		if (cs_n)
		begin
			next_count = 5'h00;
			next_sdo_oe = 1'b0;
			next_is_read = 1'b0;
		end
		else if (sclk && !sclk_prev && count != `SER_FRAME_BITS)
		begin
			next_in_shift = {in_shift[5:0], sdi};
			next_count = count + 5'h01;
			if (count == 5'h00)
				next_is_read = sdi;
			if (count == `SER_ADDR_LAST)
				next_rd_addr = {in_shift[5:0], sdi};
			if (count == `SER_DATA_LAST && !is_read)
				next_wr = {1'b1, rd_addr, in_shift[6:0], sdi};
		end
		else if (!sclk && sclk_prev && count >= `SER_DATA_FIRST && count != `SER_FRAME_BITS)
		begin
			if (count == `SER_DATA_FIRST)
			begin
				next_sdo = rd_data[7];
				next_out_shift = {rd_data[6:0], 1'b0};
				next_sdo_oe = is_read;
			end
			else
			begin
				next_sdo = out_shift[7];
				next_out_shift = {out_shift[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			sclk_prev <= 1'b0;
			is_read <= 1'b0;
			count <= 5'h00;
			in_shift <= 7'h00;
			rd_addr <= 7'h00;
			out_shift <= 8'h00;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
			wr <= '0;
		end
		else
		begin
			sclk_prev <= next_sclk_prev;
			is_read <= next_is_read;
			count <= next_count;
			in_shift <= next_in_shift;
			rd_addr <= next_rd_addr;
			out_shift <= next_out_shift;
			sdo <= next_sdo;
			sdo_oe <= next_sdo_oe;
			wr <= next_wr;
		end
	end

endmodule // serial_port

`default_nettype wire

// [ref_selector.sv]
// Purpose: Automatic reference choice among the inputs by programmed priority.
// Assumes: Index 0 is the first TTL input and index 4 the stand-by input.
// Notes: Result is registered one cycle after its inputs.
`timescale 1ns/10ps
`default_nettype none
`include "ref_input_config_defines.svh"

module ref_selector (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [`NUM_INPUTS-1:0][3:0] prio,
	input wire logic [`NUM_INPUTS-1:0] valid,
	output var logic [2:0] sel,
	output var logic sel_valid
);

	logic [2:0] next_sel;
	logic next_sel_valid;
	logic [3:0] best;
	// Inputs that the registered choice was made from, kept for the checks below.
	logic [`NUM_INPUTS-1:0][3:0] prio_q;
	logic [`NUM_INPUTS-1:0] valid_q;

	// A strict compare keeps the lowest index on equal priorities.
	always_comb
	begin
		next_sel = 3'h0;
		next_sel_valid = 1'b0;
		best = 4'hF;
		for (int i = 0; i < `NUM_INPUTS; i++)
		begin
			if (valid[i] && prio[i] != `PRIO_OFF && (!next_sel_valid || prio[i] < best))
			begin
				next_sel = 3'(i);
				next_sel_valid = 1'b1;
				best = prio[i];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			sel <= 3'h0;
			sel_valid <= 1'b0;
			prio_q <= '0;
			valid_q <= '0;
		end
		else
		begin
			sel <= next_sel;
			sel_valid <= next_sel_valid;
			prio_q <= prio;
			valid_q <= valid;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_sel_enabled;
		sel_valid |-> prio_q[sel] != `PRIO_OFF && valid_q[sel];
	endproperty
	a_sel_enabled: assert property (p_sel_enabled) else $error("selected input was disabled");

	property p_sel_best;
		sel_valid |-> !(valid_q[`IDX_STANDBY] && prio_q[`IDX_STANDBY] != `PRIO_OFF
			&& prio_q[`IDX_STANDBY] < prio_q[sel]);
	endproperty
	a_sel_best: assert property (p_sel_best) else $error("stand-by had better priority");

	property p_sel_tie;
		valid_q[0] && prio_q[0] != `PRIO_OFF && prio_q[0] <= prio_q[sel]
			|-> sel_valid && sel == 3'h0;
	endproperty
	a_sel_tie: assert property (p_sel_tie) else $error("tie not resolved to lowest index");

	property p_sel_none;
		sel_valid == |(valid_q & {prio_q[4] != 4'h0, prio_q[3] != 4'h0, prio_q[2] != 4'h0,
			prio_q[1] != 4'h0, prio_q[0] != 4'h0});
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("candidate presence mismatch");

	c_sel_standby: cover property (sel_valid && sel == `IDX_STANDBY);

endmodule // ref_selector

`default_nettype wire

// [ref_input_config_regs.sv]
// Purpose: Reference input configuration registers behind the serial port.
// Assumes: Serial pins are synchronous to clock; peer priorities come from elsewhere.
// Notes: Inputs are ordered first TTL, second TTL, first diff, second diff, stand-by.
`timescale 1ns/10ps
`default_nettype none
`include "ref_input_config_defines.svh"

module ref_input_config_regs (
	input wire logic clock,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output var logic sdo,
	output var logic sdo_oe,
	input wire logic [3:0][3:0] peer_priority,
	input wire logic [`NUM_INPUTS-1:0] input_valid,
	output var ref_cfg_pkg::input_route_s [`NUM_INPUTS-1:0] route,
	output var logic [2:0] selected_input,
	output var logic selection_valid
);

	// Returns {hit, index} for a source configuration address.
	function automatic logic [3:0] cfg_slot(input logic [6:0] a);
		case (a)
			`OFS_CFG_TTL1: cfg_slot = 4'h8;
			`OFS_CFG_TTL2: cfg_slot = 4'h9;
			`OFS_CFG_DIFF1: cfg_slot = 4'hA;
			`OFS_CFG_DIFF2: cfg_slot = 4'hB;
			`OFS_CFG_STANDBY: cfg_slot = 4'hC;
			default: cfg_slot = 4'h0;
		endcase
	endfunction

	function automatic ref_cfg_pkg::input_route_s route_of(input ref_cfg_pkg::src_cfg_s s);
		ref_cfg_pkg::input_route_s r;
		r.monitor_predivided = s.prog_div;
		r.bucket = s.bucket;
		if (s.prog_div)
			r.dpll_path = ref_cfg_pkg::PATH_PROG;
		else if (s.preset_div)
			r.dpll_path = ref_cfg_pkg::PATH_PRESET;
		else
			r.dpll_path = ref_cfg_pkg::PATH_DIRECT;
		return r;
	endfunction

	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	ref_cfg_pkg::reg_write_s wr;
	logic [3:0] standby_prio, next_standby_prio;
	ref_cfg_pkg::src_cfg_s [`NUM_INPUTS-1:0] cfg, next_cfg;
	ref_cfg_pkg::input_route_s [`NUM_INPUTS-1:0] next_route;
	logic [3:0] wr_slot, rd_slot;

	serial_port port (
		.clock(clock),
		.nrst(nrst),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdi(sdi),
		.rd_data(rd_data),
		.rd_addr(rd_addr),
		.wr(wr),
		.sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	// Upper nibble of the priority register and unmapped addresses read zero.
	always_comb
	begin
		rd_slot = cfg_slot(rd_addr);
		if (rd_addr == `OFS_STANDBY_PRIO)
			rd_data = {4'h0, standby_prio};
		else if (rd_slot[3])
			rd_data = cfg[rd_slot[2:0]];
		else
			rd_data = 8'h00;
	end

	always_comb
	begin
		wr_slot = cfg_slot(wr.addr);
		next_standby_prio = standby_prio;
		next_cfg = cfg;
		if (wr.valid && wr.addr == `OFS_STANDBY_PRIO)
			next_standby_prio = wr.data[`PRIO_HI:0];
		if (wr.valid && wr_slot[3])
			next_cfg[wr_slot[2:0]] = wr.data;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			standby_prio <= `RST_STANDBY_PRIO;
			cfg[0] <= `RST_CFG_TTL;
			cfg[1] <= `RST_CFG_TTL;
			cfg[2] <= `RST_CFG_OTHER;
			cfg[3] <= `RST_CFG_OTHER;
			cfg[4] <= `RST_CFG_OTHER;
		end
		else
		begin
			standby_prio <= next_standby_prio;
			cfg <= next_cfg;
		end
	end

	// One route per input, so each monitor gets its own bucket choice.
	always_comb
	begin
		for (int i = 0; i < `NUM_INPUTS; i++)
			next_route[i] = route_of(cfg[i]);
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			route <= '0;
		else
			route <= next_route;
	end

	ref_selector selector (
		.clock(clock),
		.nrst(nrst),
		.prio({standby_prio, peer_priority}),
		.valid(input_valid),
		.sel(selected_input),
		.sel_valid(selection_valid)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_prio_reset;
		!$past(nrst) |-> standby_prio == `RST_STANDBY_PRIO && cfg[2] == `RST_CFG_OTHER;
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("bad reset value");

	property p_prio_write;
		wr.valid && wr.addr == `OFS_STANDBY_PRIO |=> standby_prio == $past(wr.data[3:0]);
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority write lost");

	property p_prio_read;
		$rose(sdo_oe) && rd_addr == `OFS_STANDBY_PRIO |-> !sdo;
	endproperty
	a_prio_read: assert property (p_prio_read) else $error("priority read wrong");

	property p_standby_cfg_reset;
		!$past(nrst) |-> cfg[4] == `RST_CFG_OTHER && cfg[0] == `RST_CFG_TTL;
	endproperty
	a_standby_cfg_reset: assert property (p_standby_cfg_reset) else $error("cfg reset");

	property p_cfg_write;
		wr.valid && wr.addr == `OFS_CFG_STANDBY |=> cfg[4] == $past(wr.data) ##1
			route[4].bucket == $past(wr.data[5:4], 2);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("cfg write not applied");

	property p_own_bucket;
		wr.valid && wr.addr == `OFS_CFG_TTL2 |=> $stable(cfg[0]) && $stable(cfg[4]);
	endproperty
	a_own_bucket: assert property (p_own_bucket) else $error("write hit other input");

	property p_prog_path;
		cfg[2].prog_div |=> route[2].dpll_path == ref_cfg_pkg::PATH_PROG
			&& route[2].monitor_predivided;
	endproperty
	a_prog_path: assert property (p_prog_path) else $error("prog path missing");

	property p_direct_path;
		!cfg[2].prog_div && !cfg[2].preset_div |=> route[2].dpll_path == ref_cfg_pkg::PATH_DIRECT
			&& !route[2].monitor_predivided;
	endproperty
	a_direct_path: assert property (p_direct_path) else $error("direct path wrong");

	property p_preset_path;
		!cfg[0].prog_div && cfg[0].preset_div |=> route[0].dpll_path == ref_cfg_pkg::PATH_PRESET;
	endproperty
	a_preset_path: assert property (p_preset_path) else $error("preset path missing");

	property p_standby_excluded;
		(standby_prio == `PRIO_OFF && $stable(standby_prio)) [*2]
			|-> selected_input != `IDX_STANDBY || !selection_valid;
	endproperty
	a_standby_excluded: assert property (p_standby_excluded) else $error("disabled chosen");

	// The serial pin must show bit 7 of the addressed register first.
	property p_read_msb;
		$rose(sdo_oe) |-> sdo == $past(rd_data[7]);
	endproperty
	a_read_msb: assert property (p_read_msb) else $error("read bit 7 wrong");

	// Each input keeps its own bucket choice, one cycle behind its register.
	property p_bucket_ttl1;
		1'b1 |=> route[0].bucket == $past(cfg[0].bucket);
	endproperty
	a_bucket_ttl1: assert property (p_bucket_ttl1) else $error("bucket 0 wrong");

	property p_bucket_ttl2;
		1'b1 |=> route[1].bucket == $past(cfg[1].bucket);
	endproperty
	a_bucket_ttl2: assert property (p_bucket_ttl2) else $error("bucket 1 wrong");

	property p_bucket_diff1;
		1'b1 |=> route[2].bucket == $past(cfg[2].bucket);
	endproperty
	a_bucket_diff1: assert property (p_bucket_diff1) else $error("bucket 2 wrong");

	property p_bucket_diff2;
		1'b1 |=> route[3].bucket == $past(cfg[3].bucket);
	endproperty
	a_bucket_diff2: assert property (p_bucket_diff2) else $error("bucket 3 wrong");

	property p_bucket_standby;
		1'b1 |=> route[4].bucket == $past(cfg[4].bucket);
	endproperty
	a_bucket_standby: assert property (p_bucket_standby) else $error("bucket 4 wrong");

	property p_wr_ttl1;
		wr.valid && wr.addr == `OFS_CFG_TTL1 |=> cfg[0] == $past(wr.data);
	endproperty
	a_wr_ttl1: assert property (p_wr_ttl1) else $error("config 0 write lost");

	property p_wr_ttl2;
		wr.valid && wr.addr == `OFS_CFG_TTL2 |=> cfg[1] == $past(wr.data);
	endproperty
	a_wr_ttl2: assert property (p_wr_ttl2) else $error("config 1 write lost");

	property p_wr_diff1;
		wr.valid && wr.addr == `OFS_CFG_DIFF1 |=> cfg[2] == $past(wr.data);
	endproperty
	a_wr_diff1: assert property (p_wr_diff1) else $error("config 2 write lost");

	property p_wr_diff2;
		wr.valid && wr.addr == `OFS_CFG_DIFF2 |=> cfg[3] == $past(wr.data);
	endproperty
	a_wr_diff2: assert property (p_wr_diff2) else $error("config 3 write lost");

	property p_prio_only;
		wr.valid && wr.addr == `OFS_STANDBY_PRIO |=> $stable(cfg);
	endproperty
	a_prio_only: assert property (p_prio_only) else $error("priority write hit config");

	property p_cfg_only;
		wr.valid && cfg_slot(wr.addr) != 4'h0 |=> $stable(standby_prio);
	endproperty
	a_cfg_only: assert property (p_cfg_only) else $error("config write hit priority");

	property p_unmapped;
		wr.valid && wr.addr != `OFS_STANDBY_PRIO && cfg_slot(wr.addr) == 4'h0
			|=> $stable(cfg) && $stable(standby_prio);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write landed");

	property p_both_bits;
		cfg[1].prog_div && cfg[1].preset_div
			|=> route[1].dpll_path == ref_cfg_pkg::PATH_PROG && route[1].monitor_predivided;
	endproperty
	a_both_bits: assert property (p_both_bits) else $error("preset bit not ignored");

	property p_preset_mon;
		!cfg[4].prog_div && cfg[4].preset_div
			|=> route[4].dpll_path == ref_cfg_pkg::PATH_PRESET && !route[4].monitor_predivided;
	endproperty
	a_preset_mon: assert property (p_preset_mon) else $error("preset route wrong");

	property p_prog_diff2;
		cfg[3].prog_div
			|=> route[3].dpll_path == ref_cfg_pkg::PATH_PROG && route[3].monitor_predivided;
	endproperty
	a_prog_diff2: assert property (p_prog_diff2) else $error("prog route wrong");

	property p_direct_standby;
		!cfg[4].prog_div && !cfg[4].preset_div
			|=> route[4].dpll_path == ref_cfg_pkg::PATH_DIRECT && !route[4].monitor_predivided;
	endproperty
	a_direct_standby: assert property (p_direct_standby) else $error("direct route 4");

	property p_direct_ttl1;
		!cfg[0].prog_div && !cfg[0].preset_div
			|=> route[0].dpll_path == ref_cfg_pkg::PATH_DIRECT && !route[0].monitor_predivided;
	endproperty
	a_direct_ttl1: assert property (p_direct_ttl1) else $error("direct route 0");

	c_prio_write: cover property (wr.valid && wr.addr == `OFS_STANDBY_PRIO);
	c_read_cfg: cover property (sdo_oe && rd_addr == `OFS_CFG_STANDBY);
	c_preset: cover property (route[4].dpll_path == ref_cfg_pkg::PATH_PRESET);
	c_both_bits: cover property (cfg[1].prog_div && cfg[1].preset_div);

endmodule // ref_input_config_regs

`default_nettype wire

// [serial_host.sv]
// Purpose: Host model that runs one register frame at a time on the serial port.
// Assumes: Each serial clock level lasts four system clocks.
// Notes: Frame is a read flag, seven address bits and eight data bits, most significant first.
`timescale 1ns/10ps
`default_nettype none

module serial_host (
	input wire logic clock,
	output var logic cs_n,
	output var logic sclk,
	output var logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b1;
	end

	task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] word;
		word = {rd, a, d};
		q = 8'h00;
		@(negedge clock);
		cs_n = 1'b0;
		repeat (2) @(negedge clock);
		for (int i = 15; i >= 0; i--)
		begin
			sclk = 1'b0;
			sdi = word[i];
			repeat (4) @(negedge clock);
			// A read bit only counts while the device really drives the line.
			if (i < 8)
				q[i] = sdo_oe ? sdo : 1'bx;
			sclk = 1'b1;
			repeat (4) @(negedge clock);
		end
		sclk = 1'b0;
		sdi = ~word[0];
		repeat (2) @(negedge clock);
		cs_n = 1'b1;
		repeat (5) @(negedge clock);
	endtask
endmodule // serial_host

`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the reference input configuration registers.
// Assumes: The host model runs all serial frames.
// Notes: Peer priorities and input activity are driven directly.
`timescale 1ns/10ps
`default_nettype none
`include "ref_input_config_defines.svh"

module tb_top;
	logic clock;
	logic nrst;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic [3:0][3:0] peer_priority;
	logic [4:0] input_valid;
	ref_cfg_pkg::input_route_s [4:0] route;
	logic [2:0] selected_input;
	logic selection_valid;
	int errors;
	int num_checks;
	logic [7:0] q;
	logic [6:0] ofs [5] = '{`OFS_CFG_TTL1, `OFS_CFG_TTL2, `OFS_CFG_DIFF1, `OFS_CFG_DIFF2,
		`OFS_CFG_STANDBY};
	logic [7:0] cfg [5] = '{8'h52, 8'hC1, 8'hA3, 8'hB0, 8'h60};

	ref_input_config_regs u_dut (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .peer_priority(peer_priority),
		.input_valid(input_valid), .route(route), .selected_input(selected_input),
		.selection_valid(selection_valid));

	serial_host u_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe));

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_route(input int i, input logic [7:0] v);
		ref_cfg_pkg::input_route_s e;
		e.dpll_path = ref_cfg_pkg::PATH_DIRECT;
		if (v[7])
			e.dpll_path = ref_cfg_pkg::PATH_PROG;
		else if (v[6])
			e.dpll_path = ref_cfg_pkg::PATH_PRESET;
		e.monitor_predivided = v[7];
		e.bucket = v[5:4];
		num_checks++;
		if (route[i] !== e)
		begin
			errors++;
			$display("BAD route %0d expected %h seen %h", i, e, route[i]);
		end
	endtask

	task automatic chk_sel(input logic [15:0] p, input logic [4:0] v, input logic [2:0] es,
		input logic ev);
		@(negedge clock);
		peer_priority = p;
		input_valid = v;
		repeat (3) @(negedge clock);
		num_checks++;
		if (selection_valid !== ev || (ev && selected_input !== es))
		begin
			errors++;
			$display("BAD selection expected %b %h seen %b %h", ev, es, selection_valid,
				selected_input);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host.frame(1'b0, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] e);
		u_host.frame(1'b1, a, 8'h00, q);
		chk8(what, e, q);
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		errors++;
		finish_test();
	end

	initial
	begin
		nrst = 1'b0;
		peer_priority = '0;
		input_valid = 5'h1F;
		errors = 0;
		num_checks = 0;
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		rd_chk("standby priority", `OFS_STANDBY_PRIO, 8'h04);
		for (int i = 0; i < 5; i++)
		begin
			rd_chk("source config", ofs[i], i < 2 ? `RST_CFG_TTL : `RST_CFG_OTHER);
			chk_route(i, i < 2 ? `RST_CFG_TTL : `RST_CFG_OTHER);
		end
		chk_sel(16'h0000, 5'h1F, `IDX_STANDBY, 1'b1);
		$display("test reset values done");
		wr(`OFS_STANDBY_PRIO, 8'hFF);
		rd_chk("standby priority", `OFS_STANDBY_PRIO, 8'h0F);
		wr(7'h30, 8'h5A);
		rd_chk("unmapped", 7'h30, 8'h00);
		$display("test priority access done");
		for (int i = 0; i < 5; i++)
			wr(ofs[i], cfg[i]);
		for (int i = 0; i < 5; i++)
		begin
			rd_chk("source config", ofs[i], cfg[i]);
			chk_route(i, cfg[i]);
		end
		$display("test routes done");
		chk_sel(16'h3300, 5'h1F, 3'h2, 1'b1);
		chk_sel(16'h3300, 5'h1B, 3'h3, 1'b1);
		wr(`OFS_STANDBY_PRIO, 8'h01);
		chk_sel(16'h0302, 5'h1F, `IDX_STANDBY, 1'b1);
		chk_sel(16'h0302, 5'h0F, 3'h0, 1'b1);
		wr(`OFS_STANDBY_PRIO, 8'h00);
		chk_sel(16'h0302, 5'h1F, 3'h0, 1'b1);
		chk_sel(16'h0000, 5'h1F, 3'h0, 1'b0);
		$display("test selection done");
		finish_test();
	end
endmodule // tb_top

`default_nettype wire
